// [include/nvb_params.svh]
// Offsets, field positions, reset values and timing figures of the
// byte-wide nonvolatile store controller.
// Assumes inclusion by bare name from the core and the bench.
`ifndef NVB_PARAMS_SVH
`define NVB_PARAMS_SVH

// ****************************************************************
// Register byte offsets (one 32-bit word each)
// ****************************************************************
`define NVB_OFF_CTRL     4'h0
`define NVB_OFF_ADDR_LO  4'h4
`define NVB_OFF_ADDR_HI  4'h8
`define NVB_OFF_DATA     4'hC

// ****************************************************************
// Control register fields
// ****************************************************************
`define NVB_BIT_RE       0
`define NVB_BIT_PE       1
`define NVB_BIT_MPE      2
`define NVB_BIT_RIE      3
`define NVB_BIT_MODE_LO  4
`define NVB_BIT_MODE_HI  5

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define NVB_MODE_RST     2'h0
`define NVB_ERASED_BYTE  8'hFF
`define NVB_READ_STALL   3'h4
`define NVB_PROG_STALL   3'h2
`define NVB_MPE_WINDOW   3'h4
`define NVB_T_ATOMIC_US  3400
`define NVB_T_SPLIT_US   1800

`endif

// [include/nvb_pkg.sv]
// Types shared by the nonvolatile store controller.
// Assumes nvb_params.svh on the include path.
package nvb_pkg;

    // Programming modes held in the mode field
    typedef enum logic [1:0] {
        NVB_MODE_ATOMIC = 2'h0,   // Erase then write
        NVB_MODE_ERASE  = 2'h1,   // Erase only
        NVB_MODE_WRITE  = 2'h2,   // Write only
        NVB_MODE_RSVD   = 2'h3    // Reserved
    } nvb_mode_type;

    // Bus handshake states
    typedef enum logic [1:0] {
        NVB_ST_IDLE,              // Waiting for a request
        NVB_ST_STALL,             // Holding the core off
        NVB_ST_ACK                // Answer driven
    } nvb_state_type;

    // Programming job latched at launch
    typedef struct packed {
        nvb_mode_type mode;       // Operation kind
        logic [8:0]   addr;       // Target byte
        logic [7:0]   data;       // Byte to place
    } nvb_job_type;

endpackage : nvb_pkg

// [core/nvb_ctrl.sv]
// Byte-wide nonvolatile store controller with Wishbone register access.
// Assumes a classic Wishbone master on clk_i, a one-cycle oscillator
// tick synchronous to clk_i, and a global interrupt enable level.
//
// How it works
// - Own byte store, each byte independently accessible
// - Address, data, control reachable over register bus
// - Read launch stalls core four cycles
// - Program launch stalls core two cycles
// - Mode zero guarded enable does erase+write
// - Program enable stays set until done
// - No other store read or program while programming runs
// - Mode one erases held address only
// - Mode two writes without erasing first
// - Programming timed by calibrated oscillator ticks
// - Progress readable so software can poll
// - Read enable loads addressed byte into data
// - Master enable self-clears; needed for program
// - Mode locked while busy; reset unless busy
// - Ready interrupt level while idle and enabled
// - Mode code three is reserved
//
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "nvb_params.svh"

module nvb_ctrl #(
    parameter int DEPTH  = 512,          // Bytes in the store
    parameter int OSC_HZ = 8000000,      // Calibrated oscillator rate
    parameter int T_ATOMIC = `NVB_T_ATOMIC_US * (OSC_HZ / 1000000), // Ticks
    parameter int T_SPLIT  = `NVB_T_SPLIT_US * (OSC_HZ / 1000000)   // Ticks
) (
    input  wire logic        clk_i,       // CPU clock, 20 MHz
    input  wire logic        rst_i,       // Synchronous reset, high
    input  wire logic        wb_cyc_i,    // Bus cycle
    input  wire logic        wb_stb_i,    // Strobe
    input  wire logic        wb_we_i,     // Write enable
    input  wire logic [3:0]  wb_adr_i,    // Byte address
    input  wire logic [3:0]  wb_sel_i,    // Byte lanes
    input  wire logic [31:0] wb_dat_i,    // Write data
    output logic      [31:0] wb_dat_o,    // Read data
    output logic             wb_ack_o,    // Answer
    input  wire logic        osc_tick_i,  // Oscillator tick pulse
    input  wire logic        gie_i,       // Global interrupt enable
    output logic             stall_o,     // Core halted
    output logic             ready_irq_o  // Store ready interrupt
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (DEPTH < 2 || DEPTH > 512) begin : g_chk_depth
        $error("DEPTH must be 2..512");
    end
    if (T_ATOMIC < 2 || T_SPLIT < 2 || T_ATOMIC >= (1 << 24) || T_SPLIT >= (1 << 24)) begin : g_chk_time
        $error("programming tick counts out of range");
    end

    // ************************************************************
    // State
    // ************************************************************
    logic [7:0]              mem_r [DEPTH];  // Byte store
    nvb_pkg::nvb_state_type  st_r;           // Bus state
    logic [2:0]              stall_cnt_r;    // Stall cycles left
    logic [2:0]              mpe_cnt_r;      // Master enable window
    logic                    mpe_r;          // Master enable
    logic                    pe_r = 1'b0;    // Busy; survives reset
    logic [23:0]             tick_cnt_r;     // Ticks left
    nvb_pkg::nvb_job_type    job_r;          // Latched job
    nvb_pkg::nvb_mode_type   mode_r;         // Mode field
    logic                    rie_r;          // Ready irq enable
    logic [8:0]              addr_r;         // Address register
    logic [7:0]              data_r;         // Data register

    // Register hit on a word offset
    function automatic logic hit(input logic [3:0] adr, input logic [3:0] off);
        hit = (adr[3:2] == off[3:2]);
    endfunction : hit

    // ************************************************************
    // Request decode
    // ************************************************************
    logic req;          // New request this cycle
    logic ctrl_wr;      // Write to control low lane
    logic rd_launch;    // Read of the store starts
    logic pg_launch;    // Programming starts
    assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o && st_r == nvb_pkg::NVB_ST_IDLE && !rst_i;
    assign ctrl_wr   = req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, `NVB_OFF_CTRL);
    // Read refused while busy
    assign rd_launch = ctrl_wr && wb_dat_i[`NVB_BIT_RE] && !pe_r;
    // Guarded by master enable, blocked when busy or reserved
    assign pg_launch = ctrl_wr && wb_dat_i[`NVB_BIT_PE] && mpe_r && !pe_r
                       && mode_r != nvb_pkg::NVB_MODE_RSVD;

    // ************************************************************
    // Bus handshake and core stall
    // ************************************************************
    // Launches hold the answer back while the core is stalled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r        <= nvb_pkg::NVB_ST_IDLE;
            stall_cnt_r <= 3'h0;
            wb_ack_o    <= 1'b0;
            stall_o     <= 1'b0;
        end else begin
            unique case (st_r)
                nvb_pkg::NVB_ST_IDLE: begin
                    if (rd_launch) begin
                        st_r        <= nvb_pkg::NVB_ST_STALL;
                        stall_cnt_r <= `NVB_READ_STALL - 3'h1;
                        stall_o     <= 1'b1;
                    end else if (pg_launch) begin
                        st_r        <= nvb_pkg::NVB_ST_STALL;
                        stall_cnt_r <= `NVB_PROG_STALL - 3'h1;
                        stall_o     <= 1'b1;
                    end else if (req) begin
                        st_r     <= nvb_pkg::NVB_ST_ACK;
                        wb_ack_o <= 1'b1;
                    end
                end
                nvb_pkg::NVB_ST_STALL: begin
                    // Count down, then answer
                    if (stall_cnt_r == 3'h0) begin
                        st_r     <= nvb_pkg::NVB_ST_ACK;
                        stall_o  <= 1'b0;
                        wb_ack_o <= 1'b1;
                    end else begin
                        stall_cnt_r <= stall_cnt_r - 3'h1;
                    end
                end
                nvb_pkg::NVB_ST_ACK: begin
                    // Answer lasts one cycle
                    st_r     <= nvb_pkg::NVB_ST_IDLE;
                    wb_ack_o <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    // Registered read mux; unused bits read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0;
        end else if (req && !wb_we_i) begin
            wb_dat_o <= 32'h0;
            if (hit(wb_adr_i, `NVB_OFF_CTRL)) begin
                wb_dat_o[`NVB_BIT_MODE_HI:`NVB_BIT_MODE_LO] <= mode_r;
                wb_dat_o[`NVB_BIT_RIE] <= rie_r;
                wb_dat_o[`NVB_BIT_MPE] <= mpe_r;
                wb_dat_o[`NVB_BIT_PE]  <= pe_r;
            end else if (hit(wb_adr_i, `NVB_OFF_ADDR_LO)) begin
                wb_dat_o[7:0] <= addr_r[7:0];
            end else if (hit(wb_adr_i, `NVB_OFF_ADDR_HI)) begin
                wb_dat_o[0] <= addr_r[8];
            end else begin
                wb_dat_o[7:0] <= data_r;
            end
        end
    end

    // ************************************************************
    // Master enable window
    // ************************************************************
    // Set by software, cleared by hardware after four cycles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mpe_r     <= 1'b0;
            mpe_cnt_r <= 3'h0;
        end else if (ctrl_wr && wb_dat_i[`NVB_BIT_MPE]) begin
            mpe_r     <= 1'b1;
            mpe_cnt_r <= `NVB_MPE_WINDOW - 3'h1;
        end else if (mpe_r) begin
            if (mpe_cnt_r == 3'h0) begin
                mpe_r <= 1'b0;
            end else begin
                mpe_cnt_r <= mpe_cnt_r - 3'h1;
            end
        end
    end

    // ************************************************************
    // Mode and ready interrupt enable
    // ************************************************************
    // Mode frozen while busy; reset spares it when busy
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rie_r <= 1'b0;
            if (!pe_r) begin
                mode_r <= nvb_pkg::nvb_mode_type'(`NVB_MODE_RST);
            end
        end else if (ctrl_wr) begin
            rie_r <= wb_dat_i[`NVB_BIT_RIE];
            if (!pe_r) begin
                mode_r <= nvb_pkg::nvb_mode_type'(wb_dat_i[`NVB_BIT_MODE_HI:`NVB_BIT_MODE_LO]);
            end
        end
    end

    // ************************************************************
    // Address and data registers
    // ************************************************************
    // Address written by software from the low lane
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_r <= 9'h000;
        end else if (req && wb_we_i && wb_sel_i[0]) begin
            if (hit(wb_adr_i, `NVB_OFF_ADDR_LO)) begin
                addr_r[7:0] <= wb_dat_i[7:0];
            end else if (hit(wb_adr_i, `NVB_OFF_ADDR_HI)) begin
                addr_r[8] <= wb_dat_i[0];
            end
        end
    end

    // Data written by software or loaded by a read launch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_r <= 8'h00;
        end else if (rd_launch) begin
            data_r <= mem_r[addr_r % DEPTH];
        end else if (req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, `NVB_OFF_DATA)) begin
            data_r <= wb_dat_i[7:0];
        end
    end

    // ************************************************************
    // Programming engine
    // ************************************************************
    // Busy from launch to end; counts oscillator ticks only
    always_ff @(posedge clk_i) begin
        if (pg_launch) begin
            pe_r       <= 1'b1;
            // Job copied so later register writes cannot disturb it
            job_r      <= '{mode: mode_r, addr: addr_r, data: data_r};
            tick_cnt_r <= (mode_r == nvb_pkg::NVB_MODE_ATOMIC) ? 24'(T_ATOMIC) : 24'(T_SPLIT);
        end else if (pe_r && osc_tick_i) begin
            if (tick_cnt_r == 24'h1) begin
                pe_r <= 1'b0;
            end
            tick_cnt_r <= tick_cnt_r - 24'h1;
        end
    end

    // Store update when the job finishes
    always_ff @(posedge clk_i) begin
        if (pe_r && osc_tick_i && tick_cnt_r == 24'h1) begin
            unique case (job_r.mode)
                nvb_pkg::NVB_MODE_ATOMIC: mem_r[job_r.addr % DEPTH] <= job_r.data;
                nvb_pkg::NVB_MODE_ERASE:  mem_r[job_r.addr % DEPTH] <= `NVB_ERASED_BYTE;
                // Unerased target keeps only common ones
                nvb_pkg::NVB_MODE_WRITE:  mem_r[job_r.addr % DEPTH] <= mem_r[job_r.addr % DEPTH] & job_r.data;
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Ready interrupt
    // ************************************************************
    // Constant level while store idle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ready_irq_o <= 1'b0;
        end else begin
            ready_irq_o <= rie_r && gie_i && !pe_r;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    // Core stall lengths after each launch, one-cycle answer
    read_stall_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_launch |=> stall_o [*4] ##1 (wb_ack_o && !stall_o))
        else $error("read stall not four cycles");
    prog_stall_a: assert property (@(posedge clk_i) disable iff (rst_i)
        pg_launch |=> stall_o [*2] ##1 (wb_ack_o && !stall_o))
        else $error("program stall not two cycles");
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("bus answer longer than one cycle");

    // Two-key guard: live for four edges after the master write
    mpe_window_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_wr && wb_dat_i[`NVB_BIT_MPE]) ##1 !(ctrl_wr && wb_dat_i[`NVB_BIT_MPE]) [*4]
        |=> !mpe_r)
        else $error("master enable not cleared after four cycles");
    pe_guard_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_wr && wb_dat_i[`NVB_BIT_PE] && !mpe_r && !pe_r) |=> !pe_r)
        else $error("program enable took effect without master enable");
    rsvd_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_wr && wb_dat_i[`NVB_BIT_PE] && mode_r == nvb_pkg::NVB_MODE_RSVD && !pe_r) |=> !pe_r)
        else $error("reserved mode started programming");

    // Busy flag, oscillator timing and the latched job
    pe_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (pe_r && !(osc_tick_i && tick_cnt_r == 24'h1)) |=> pe_r)
        else $error("program enable dropped early");
    osc_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (pe_r && !osc_tick_i) |=> $stable(tick_cnt_r))
        else $error("programming time advanced without oscillator tick");
    job_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
        pg_launch |=> pe_r && job_r.addr == $past(addr_r) && job_r.data == $past(data_r))
        else $error("job not latched from held address and data");

    // Requests refused while a job runs
    busy_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_wr && wb_dat_i[`NVB_BIT_RE] && pe_r && !(req && hit(wb_adr_i, `NVB_OFF_DATA)))
        |=> $stable(data_r) && !stall_o)
        else $error("read accepted while busy");
    busy_prog_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_wr && wb_dat_i[`NVB_BIT_PE] && pe_r) |=> $stable(job_r) && !stall_o)
        else $error("program enable accepted while busy");
    mode_lock_a: assert property (@(posedge clk_i)
        pe_r |=> $stable(mode_r))
        else $error("mode changed while busy");

    // Reset spares a running job; clears an idle mode
    busy_reset_a: assert property (@(posedge clk_i)
        (rst_i && pe_r && !(osc_tick_i && tick_cnt_r == 24'h1)) |=> pe_r)
        else $error("reset stopped a running job");
    mode_reset_a: assert property (@(posedge clk_i)
        (rst_i && !pe_r) |=> mode_r == nvb_pkg::NVB_MODE_ATOMIC)
        else $error("mode not cleared by idle reset");

    // Interrupt follows its enables one cycle late
    ready_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 ready_irq_o == $past(rie_r && gie_i && !pe_r))
        else $error("ready interrupt level wrong");

    // ************************************************************
    // Cover points
    // ************************************************************
    // Each programming mode, a read launch and a reset mid-job
    atomic_c: cover property (@(posedge clk_i) pg_launch && mode_r == nvb_pkg::NVB_MODE_ATOMIC);
    erase_c:  cover property (@(posedge clk_i) pg_launch && mode_r == nvb_pkg::NVB_MODE_ERASE);
    write_c:  cover property (@(posedge clk_i) pg_launch && mode_r == nvb_pkg::NVB_MODE_WRITE);
    read_c:   cover property (@(posedge clk_i) rd_launch);
    reset_busy_c: cover property (@(posedge clk_i) rst_i && pe_r);

endmodule : nvb_ctrl
`default_nettype wire

// [test/nvb_core_model.sv]
// Core-side model: calibrated oscillator tick source and stall meter.
// Assumes clk_i is the CPU clock and stall_i comes from the controller.
`timescale 1ns/1ps
`default_nettype none

module nvb_core_model #(
    parameter int TICK_DIV = 4            // CPU cycles per oscillator tick
) (
    input  wire logic       clk_i,        // CPU clock
    input  wire logic       rst_i,        // Synchronous reset
    input  wire logic       tick_en_i,    // Oscillator running
    input  wire logic       stall_i,      // Core held by controller
    output logic            osc_tick_o,   // One-cycle tick pulse
    output logic [7:0]      stall_len_o   // Length of the last stall
);
    logic [7:0] div_r;                    // Tick divider
    logic       stall_q_r;                // Stall seen last cycle

    // ****************************************************************
    // Tick source, divided down from the CPU clock by TICK_DIV
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i || !tick_en_i || div_r == TICK_DIV - 1) begin
            div_r <= 8'h00;
        end else begin
            div_r <= div_r + 8'h01;
        end
        osc_tick_o <= tick_en_i && !rst_i && div_r == TICK_DIV - 1;
    end

    // Count cycles the core stays halted, restart on each new halt
    always_ff @(posedge clk_i) begin
        stall_q_r <= stall_i;
        if (stall_i && !stall_q_r) begin
            stall_len_o <= 8'h01;
        end else if (stall_i) begin
            stall_len_o <= stall_len_o + 8'h01;
        end
    end
endmodule : nvb_core_model

`default_nettype wire

// [test/nvb_ctrl_tb.sv]
// Self-checking bench for the nonvolatile store controller.
// Assumes nvb_params.svh on the include path and short programming counts.
`timescale 1ns/1ps
`default_nettype none
`include "nvb_params.svh"

module nvb_ctrl_tb;
    logic        clk_i = 1'b0, rst_i = 1'b1, gie_i = 1'b0, tick_en = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0]  adr = 4'h0, sel = 4'h0;
    logic [31:0] dat = 32'h0, wb_dat_o, rdata;
    logic        wb_ack_o, osc_tick, stall_o, ready_irq_o;
    logic [7:0]  stall_len;
    int          err_count = 0, tests_run = 0, lat = 0;

    nvb_ctrl #(.T_ATOMIC(5), .T_SPLIT(3)) nvb_ctrl_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .osc_tick_i(osc_tick), .gie_i(gie_i),
        .stall_o(stall_o), .ready_irq_o(ready_irq_o));

    nvb_core_model nvb_core_model_inst (
        .clk_i(clk_i), .rst_i(rst_i), .tick_en_i(tick_en), .stall_i(stall_o),
        .osc_tick_o(osc_tick), .stall_len_o(stall_len));

    // ****************************************************************
    // Clock, watchdog and verdict
    // ****************************************************************
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    initial begin
        #(50 * 20000);
        err_count++;
        close_out();
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // ****************************************************************
    // Classic Wishbone cycle; caller stands just after a rising edge
    // ****************************************************************
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        sel <= 4'hF;
        dat <= {24'h000000, d};
        lat = 0;
        do begin
            @(posedge clk_i);
            lat++;
        end while (wb_ack_o !== 1'b1 && lat < 50);
        if (lat >= 50) err_count++;
        rdata = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [3:0] a);
        bus(1'b0, a, 8'h00);
    endtask : rd

    // Poll the busy bit until programming ends
    task automatic wait_idle();
        for (int i = 0; i < 100; i++) begin
            rd(`NVB_OFF_CTRL);
            if (rdata[1] === 1'b0) return;
        end
        err_count++;
    endtask : wait_idle

    // Guarded programming sequence: mode, address, data, master, program
    task automatic prog(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d);
        wait_idle();
        wr(`NVB_OFF_CTRL, {2'h0, m, 4'h0});
        wr(`NVB_OFF_ADDR_LO, a[7:0]);
        wr(`NVB_OFF_ADDR_HI, {7'h00, a[8]});
        wr(`NVB_OFF_DATA, d);
        wr(`NVB_OFF_CTRL, {2'h0, m, 4'h4});
        wr(`NVB_OFF_CTRL, {2'h0, m, 4'h6});
    endtask : prog

    // Read a stored byte through the read launch
    task automatic fetch(input logic [8:0] a);
        wait_idle();
        wr(`NVB_OFF_ADDR_LO, a[7:0]);
        wr(`NVB_OFF_ADDR_HI, {7'h00, a[8]});
        wr(`NVB_OFF_CTRL, 8'h01);
        check(lat, 6);
        check(stall_len, 8'h04);
        rd(`NVB_OFF_DATA);
    endtask : fetch

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(`NVB_OFF_CTRL);
        check(rdata, 32'h0);
        rd(`NVB_OFF_DATA);
        check(rdata, 32'h0);
        $display("test reset values done");
        // Atomic program with the oscillator held still
        tick_en <= 1'b0;
        prog(2'h0, 9'h1A5, 8'h3C);
        check(lat, 4);
        check(stall_len, 8'h02);
        repeat (40) @(posedge clk_i);
        rd(`NVB_OFF_CTRL);
        check(rdata[1], 1'b1);
        wr(`NVB_OFF_CTRL, 8'h04);
        wr(`NVB_OFF_CTRL, 8'h13);
        check(lat, 2);
        rd(`NVB_OFF_CTRL);
        check(rdata[5:4], 2'h0);
        rd(`NVB_OFF_DATA);
        check(rdata[7:0], 8'h3C);
        tick_en <= 1'b1;
        fetch(9'h1A5);
        check(rdata[7:0], 8'h3C);
        $display("test atomic program done");
        // Erase first, so the write-only pass lands on a clean byte
        prog(2'h1, 9'h1A5, 8'h00);
        // Reset mid-job: busy and mode survive, the rest clears
        tick_en <= 1'b0;
        rst_i   <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i   <= 1'b0;
        @(posedge clk_i);
        rd(`NVB_OFF_CTRL);
        check(rdata, 32'h12);
        tick_en <= 1'b1;
        fetch(9'h1A5);
        check(rdata[7:0], 8'hFF);
        prog(2'h2, 9'h1A5, 8'h5A);
        fetch(9'h1A5);
        check(rdata[7:0], 8'h5A);
        $display("test split program done");
        // Unguarded, late and reserved-mode program enables
        wr(`NVB_OFF_CTRL, 8'h02);
        check(lat, 2);
        wr(`NVB_OFF_CTRL, 8'h04);
        repeat (6) @(posedge clk_i);
        wr(`NVB_OFF_CTRL, 8'h02);
        check(lat, 2);
        rd(`NVB_OFF_CTRL);
        check(rdata[2:1], 2'h0);
        prog(2'h3, 9'h1A5, 8'h00);
        check(lat, 2);
        fetch(9'h1A5);
        check(rdata[7:0], 8'h5A);
        $display("test refused launches done");
        // Ready interrupt: gated by the global enable, low while busy
        wr(`NVB_OFF_CTRL, 8'h08);
        repeat (3) @(posedge clk_i);
        check(ready_irq_o, 1'b0);
        gie_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        check(ready_irq_o, 1'b1);
        wr(`NVB_OFF_CTRL, 8'h0C);
        wr(`NVB_OFF_CTRL, 8'h0E);
        repeat (2) @(posedge clk_i);
        check(ready_irq_o, 1'b0);
        wait_idle();
        repeat (3) @(posedge clk_i);
        check(ready_irq_o, 1'b1);
        $display("test ready interrupt done");
        close_out();
    end
endmodule : nvb_ctrl_tb

`default_nettype wire
